/* File: pkg/pmw_pkg.sv */
// Package of offsets, field positions, reset values and carrier types for the PM and window CSR block
package pmw_pkg;

	// ---------------------------------------------------------------
	// Register byte addresses
	// ---------------------------------------------------------------
	localparam logic [7:0]  PMW_OFS_PMCSR     = 8'h94;  // Power control/status + bridge extension
	localparam logic [7:0]  PMW_OFS_XLAT      = 8'h98;  // Window 0 translated base
	localparam logic [7:0]  PMW_OFS_SETUP     = 8'h9C;  // Window 0 setup
	localparam logic [7:0]  PMW_OFS_SETUP_LD  = 8'hA8;  // Setup path load port
	localparam logic [7:0]  PMW_OFS_IRQ_STAT  = 8'hAC;  // Sticky event status
	localparam logic [7:0]  PMW_OFS_IRQ_EN    = 8'hB0;  // Event enable
	localparam logic [7:0]  PMW_OFS_IRQ_CLR   = 8'hB4;  // Write-one-to-clear events

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int PMW_POS_WAKE_EN   = 8;   // Wake enable bit
	localparam int PMW_POS_WAKE_ST   = 15;  // Wake status bit
	localparam int PMW_POS_COUPLING  = 22;  // Bus sleep coupling support
	localparam int PMW_POS_BUSCTL    = 23;  // Bus power/clock control
	localparam int PMW_POS_WIN_EN    = 31;  // Window enable

	// ---------------------------------------------------------------
	// Codes and reset values
	// ---------------------------------------------------------------
	localparam logic [1:0]  PMW_PS_FULL_ON   = 2'h0;     // Full-on state
	localparam logic [1:0]  PMW_PS_SLEEP     = 2'h3;     // Deepest sleep state
	localparam logic [1:0]  PMW_ATYPE_32     = 2'h0;     // 32-bit window
	localparam logic [1:0]  PMW_ATYPE_64     = 2'h1;     // 64-bit window
	localparam logic [18:0] PMW_MASK_RST     = 19'h7FFFF; // Size mask reset
	localparam logic [19:0] PMW_XLAT_RST     = 20'h00000; // Translated base reset
	localparam logic [4:0]  PMW_WAKE_CAP     = 5'h19;    // Wake capability 11001
	localparam logic [31:0] PMW_UNMAPPED     = 32'h00000000; // Unmapped read value
	localparam int          PMW_RESET_CYCLES = 4;        // Internal reset pulse length

	// Interrupt event bits
	localparam int PMW_EV_WAKE   = 0;  // Wake status raised
	localparam int PMW_EV_PSWAKE = 1;  // Sleep to full-on write, reset pulse started
	localparam int PMW_EV_BADPS  = 2;  // Unimplemented power state write
	localparam int PMW_EV_W      = 3;  // Number of events

	// ---------------------------------------------------------------
	// Carrier types
	// ---------------------------------------------------------------
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} pmw_apb_req_type;

	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
	} pmw_addr_type;

endpackage : pmw_pkg

/* File: design/pmw_csr.sv */
// Power-management CSR and downstream window 0 translation block with APB slave
//
// Summary of operation
// - Power state: 00 full-on, 11 deepest sleep
// - Power-state codes 01/10 are discarded on write; other fields of the write still apply
// - Sleep to full-on write pulses internal reset
// - Bit 8 sticky wake enable, resets 0
// - Bit 15 wake status, write-one clears
// - Power-data fields read as zero
// - Extension bits 22 and 23 read 0
// - Translated base bits 31:12 RW, reset 0
// - Size mask selects effective translated bits
// - Setup bit 0 reads 0, memory space
// - Address type RO, setup loaded, reset 00
// - All base bits writable; mask ones select 30:12, bit 31 always selected
// - Enable resets 1, zero writes forced 1
// - Wake capability reported as 11001
//
// Implementation choice: register access over APB.
`timescale 1ns/10ps

module pmw_csr
	import pmw_pkg::*;
#(
	parameter int RESET_CYCLES = PMW_RESET_CYCLES  // Internal reset pulse length
) (
	input  wire logic        CLK,
	input  wire logic        RST_N,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        WAKE_EVENT_IN,
	input  wire logic        DS_VALID,
	input  wire logic [31:0] DS_ADDR,
	output logic             FWD_VALID,
	output logic      [31:0] FWD_ADDR,
	output logic             WAKE_EVENT_OUT_N,
	output logic             INTERNAL_RESET,
	output logic      [4:0]  WAKE_CAPABILITY,
	output logic             IRQ
);

	// ---------------------------------------------------------------
	// Input synchronisers
	// ---------------------------------------------------------------
	logic        wake_meta_r;       // First stage, read only by second
	logic        wake_sync_r;       // Synchronised wake request
	logic        wake_prev_r;       // For rising edge detect

	// Pin is asynchronous to CLK, so two stages before use
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			wake_meta_r <= 1'b0;
			wake_sync_r <= 1'b0;
			wake_prev_r <= 1'b0;
		end else begin
			wake_meta_r <= WAKE_EVENT_IN;
			wake_sync_r <= wake_meta_r;
			wake_prev_r <= wake_sync_r;
		end
	end

	wire wake_rise = wake_sync_r & ~wake_prev_r;  // New wake event

	// ---------------------------------------------------------------
	// Bus decode
	// ---------------------------------------------------------------
	pmw_apb_req_type req;               // Bundled request
	assign req = '{psel: PSEL, penable: PENABLE, pwrite: PWRITE, paddr: PADDR, pwdata: PWDATA};

	// One wait state: ready follows the first access cycle
	wire acc      = req.psel & req.penable;
	// Writes land only at the edge where ready is seen, so none lands twice
	wire wr       = acc & req.pwrite & PREADY;
	wire rd       = acc & ~req.pwrite;
	wire sel_pm   = (req.paddr == PMW_OFS_PMCSR);
	wire sel_xl   = (req.paddr == PMW_OFS_XLAT);
	wire sel_su   = (req.paddr == PMW_OFS_SETUP);
	wire sel_ld   = (req.paddr == PMW_OFS_SETUP_LD);
	wire sel_ist  = (req.paddr == PMW_OFS_IRQ_STAT);
	wire sel_ien  = (req.paddr == PMW_OFS_IRQ_EN);
	wire sel_icl  = (req.paddr == PMW_OFS_IRQ_CLR);
	wire mapped   = sel_pm | sel_xl | sel_su | sel_ld | sel_ist | sel_ien | sel_icl;
	wire [31:0] wd = req.pwdata;

	// ---------------------------------------------------------------
	// Power state and wake
	// ---------------------------------------------------------------
	logic [1:0]  pstate_r;          // Power state
	logic        wake_en_r;         // Sticky wake enable
	logic        wake_st_r;         // Sticky wake status

	wire [1:0] ps_wr     = wd[1:0];
	wire       ps_legal  = (ps_wr == PMW_PS_FULL_ON) | (ps_wr == PMW_PS_SLEEP);
	wire       ps_take   = wr & sel_pm & ps_legal;
	wire       ps_bad    = wr & sel_pm & ~ps_legal;
	wire       ps_wakeup = ps_take & (pstate_r == PMW_PS_SLEEP) & (ps_wr == PMW_PS_FULL_ON);
	wire       wst_clr   = wr & sel_pm & wd[PMW_POS_WAKE_ST];

	// Illegal codes leave the held state untouched
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			pstate_r <= PMW_PS_FULL_ON;
		end else if (ps_take) begin
			pstate_r <= ps_wr;
		end
	end

	// Sticky bits live through the internal reset, only RST_N clears them
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			wake_en_r <= 1'b0;
		end else if (wr & sel_pm) begin
			wake_en_r <= wd[PMW_POS_WAKE_EN];
		end
	end

	// Set beats a simultaneous write-one clear
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			wake_st_r <= 1'b0;
		end else if (wake_rise) begin
			wake_st_r <= 1'b1;
		end else if (wst_clr) begin
			wake_st_r <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Internal reset pulse on sleep to full-on
	// ---------------------------------------------------------------
	logic [7:0]  rst_cnt_r;         // Remaining pulse cycles
	logic        int_rst_r;         // Internal reset output

	// Secondary bus reset pin is deliberately not touched here
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			rst_cnt_r <= 8'h00;
			int_rst_r <= 1'b0;
		end else if (ps_wakeup) begin
			rst_cnt_r <= 8'(RESET_CYCLES - 1);
			int_rst_r <= 1'b1;
		end else if (rst_cnt_r != 8'h00) begin
			rst_cnt_r <= rst_cnt_r - 8'h01;
		end else begin
			int_rst_r <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Window 0 translated base and setup
	// ---------------------------------------------------------------
	logic [19:0] xlat_r;            // Translated base 31:12
	logic [1:0]  atype_r;           // Address type
	logic        pref_r;            // Prefetchable
	logic [18:0] mask_r;            // Size mask 30:12

	// Internal reset returns the window to its reset state too
	wire win_rst = !RST_N | int_rst_r;
	wire ld_wr   = wr & sel_ld;
	wire [1:0] atype_ld = (wd[2:1] == PMW_ATYPE_64) ? PMW_ATYPE_64 : PMW_ATYPE_32;

	always_ff @(posedge CLK) begin
		if (win_rst) begin
			xlat_r <= PMW_XLAT_RST;
		end else if (wr & sel_xl) begin
			xlat_r <= wd[31:12];
		end
	end

	// Ordinary writes to the setup offset do nothing; the load port sets fields
	always_ff @(posedge CLK) begin
		if (win_rst) begin
			atype_r <= PMW_ATYPE_32;
			pref_r  <= 1'b0;
			mask_r  <= PMW_MASK_RST;
		end else if (ld_wr) begin
			atype_r <= atype_ld;
			pref_r  <= wd[3];
			mask_r  <= wd[30:12];
		end
	end

	// Enable bit is constant one: zero writes are overridden
	wire [31:0] setup_rd = {1'b1, mask_r, 8'h00, pref_r, atype_r, 1'b0};
	// Base bit 31 is always live; 30:12 follow the mask
	wire [19:0] eff_mask = {1'b1, mask_r};

	// ---------------------------------------------------------------
	// Downstream address translation
	// ---------------------------------------------------------------
	wire [31:0] fwd_nxt = {(xlat_r & eff_mask) | (DS_ADDR[31:12] & ~eff_mask), DS_ADDR[11:0]};
	pmw_addr_type fwd_r;            // Registered forwarded address

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			fwd_r <= '0;
		end else begin
			fwd_r <= '{valid: DS_VALID, addr: fwd_nxt};
		end
	end

	// ---------------------------------------------------------------
	// Interrupt block
	// ---------------------------------------------------------------
	logic [PMW_EV_W-1:0] ist_r;    // Sticky event status
	logic [PMW_EV_W-1:0] ien_r;    // Event enable
	logic                irq_r;    // Level interrupt

	wire [PMW_EV_W-1:0] ev_set = {ps_bad, ps_wakeup, wake_rise};
	wire [PMW_EV_W-1:0] ev_clr = (wr & sel_icl) ? wd[PMW_EV_W-1:0] : '0;

	// Set wins over clear in the same cycle
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			ist_r <= '0;
			ien_r <= '0;
			irq_r <= 1'b0;
		end else begin
			ist_r <= (ist_r & ~ev_clr) | ev_set;
			if (wr & sel_ien) begin
				ien_r <= wd[PMW_EV_W-1:0];
			end
			irq_r <= |(((ist_r & ~ev_clr) | ev_set) & ((wr & sel_ien) ? wd[PMW_EV_W-1:0] : ien_r));
		end
	end

	// ---------------------------------------------------------------
	// Read mux
	// ---------------------------------------------------------------
	// Data fields stay zero: no power-data reporting exists
	wire [31:0] pm_rd = {8'h00, 1'b0, 1'b0, 6'h00,
	                     wake_st_r, 2'h0, 4'h0, wake_en_r, 6'h00, pstate_r};

	wire [31:0] rd_mux =
		sel_pm  ? pm_rd :
		sel_xl  ? {xlat_r, 12'h000} :
		sel_su  ? setup_rd :
		sel_ist ? {{(32-PMW_EV_W){1'b0}}, ist_r} :
		sel_ien ? {{(32-PMW_EV_W){1'b0}}, ien_r} :
		PMW_UNMAPPED;

	// ---------------------------------------------------------------
	// Output registers
	// ---------------------------------------------------------------
	logic [31:0] prdata_r;          // Read data
	logic        pready_r;          // Ready
	logic        pslverr_r;         // Error
	logic        wake_n_r;          // Wake output, active low

	// Ready is registered, so each access waits exactly one cycle
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			prdata_r  <= '0;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			wake_n_r  <= 1'b1;
		end else begin
			pready_r  <= acc & ~pready_r;
			pslverr_r <= acc & ~pready_r & ~mapped;
			prdata_r  <= (rd & ~pready_r) ? rd_mux : 32'h00000000;
			wake_n_r  <= ~(wake_st_r & wake_en_r);
		end
	end

	assign PRDATA           = prdata_r;
	assign PREADY           = pready_r;
	assign PSLVERR          = pslverr_r;
	assign FWD_VALID        = fwd_r.valid;
	assign FWD_ADDR         = fwd_r.addr;
	assign WAKE_EVENT_OUT_N = wake_n_r;
	assign INTERNAL_RESET   = int_rst_r;
	assign IRQ              = irq_r;

	// Capability constant held in a flop so the output is registered
	logic [4:0] cap_r;
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			cap_r <= PMW_WAKE_CAP;
		end else begin
			cap_r <= PMW_WAKE_CAP;
		end
	end
	assign WAKE_CAPABILITY = cap_r;

endmodule // pmw_csr

/* File: tb/pmw_csr_checker.sv */
// Port-level assertions for the PM and window CSR block
`timescale 1ns/10ps

module pmw_csr_checker
	import pmw_pkg::*;
#(
	parameter int RESET_CYCLES = PMW_RESET_CYCLES  // Internal reset length
) (
	input wire logic        CLK,
	input wire logic        RST_N,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [7:0]  PADDR,
	input wire logic [31:0] PRDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	input wire logic        DS_VALID,
	input wire logic [31:0] DS_ADDR,
	input wire logic        FWD_VALID,
	input wire logic [31:0] FWD_ADDR,
	input wire logic        INTERNAL_RESET,
	input wire logic [4:0]  WAKE_CAPABILITY
);
	// ----------------------------------------
	// Helper logic
	// ----------------------------------------
	logic [7:0] ir_len_r;                // High cycles of internal reset
	wire        rd_ok = PREADY && !PWRITE;  // Read answer cycle

	// Counter, since a repetition cannot take a parameter
	always_ff @(posedge CLK) begin
		if (!RST_N || !INTERNAL_RESET) ir_len_r <= 8'h00;
		else ir_len_r <= ir_len_r + 8'h01;
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_ready; PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY; endproperty
	a_ready: assert property (p_ready) else $error("ready not a single pulse after access");
	property p_slverr; PSLVERR |-> PREADY && PRDATA == 32'h00000000; endproperty
	a_slverr: assert property (p_slverr) else $error("error flag outside answer");
	property p_pm_zero; rd_ok && PADDR == PMW_OFS_PMCSR |->
		PRDATA[31:16] == 16'h0000 && PRDATA[14:9] == 6'h00 && PRDATA[7:2] == 6'h00; endproperty
	a_pm_zero: assert property (p_pm_zero) else $error("power fields not zero");
	property p_xlat; rd_ok && PADDR == PMW_OFS_XLAT |-> PRDATA[11:0] == 12'h000; endproperty
	a_xlat: assert property (p_xlat) else $error("base low bits not zero");
	property p_setup; rd_ok && PADDR == PMW_OFS_SETUP |->
		PRDATA[31] && !PRDATA[0] && !PRDATA[2] && PRDATA[11:4] == 8'h00; endproperty
	a_setup: assert property (p_setup) else $error("setup fixed bits wrong");
	property p_fwd; DS_VALID |=> FWD_VALID && ((FWD_ADDR ^ $past(DS_ADDR)) & 32'h00000FFF) == 32'h0; endproperty
	a_fwd: assert property (p_fwd) else $error("forwarded address late or low bits changed");
	property p_cap; WAKE_CAPABILITY == PMW_WAKE_CAP; endproperty
	a_cap: assert property (p_cap) else $error("wake capability wrong");
	property p_irst; $fell(INTERNAL_RESET) |-> ir_len_r == RESET_CYCLES; endproperty
	a_irst: assert property (p_irst) else $error("internal reset length wrong");
endmodule // pmw_csr_checker

bind pmw_csr pmw_csr_checker #(.RESET_CYCLES(RESET_CYCLES)) pmw_csr_checker_inst (
	.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
	.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .DS_VALID(DS_VALID), .DS_ADDR(DS_ADDR),
	.FWD_VALID(FWD_VALID), .FWD_ADDR(FWD_ADDR), .INTERNAL_RESET(INTERNAL_RESET),
	.WAKE_CAPABILITY(WAKE_CAPABILITY)
);

/* File: tb/pmw_host.sv */
// Host model issuing APB configuration accesses
`timescale 1ns/10ps

module pmw_host
	import pmw_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        PREADY,
	input  wire logic        PSLVERR,
	input  wire logic [31:0] PRDATA,
	output pmw_apb_req_type  req
);
	initial req = '0;  // Bus idle at time zero

	// One transfer; request held until ready is sampled high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] rd, output logic err, output bit tmo);
		int n;
		@(posedge CLK);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge CLK);
		req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge CLK);
			n++;
		end while (PREADY !== 1'b1 && n < 20);
		tmo = (PREADY !== 1'b1);
		rd = PRDATA;
		err = PSLVERR;
		// Released lines show inverted leftovers, not stale values
		req <= '{psel: 1'b0, penable: 1'b0, pwrite: ~w, paddr: ~a, pwdata: ~d};
	endtask
endmodule // pmw_host

/* File: tb/pmw_csr_tb_top.sv */
// Self-checking testbench top for the PM and window CSR block
`timescale 1ns/10ps

module pmw_csr_tb_top
	import pmw_pkg::*;
;
	localparam int IRST = 4;  // Internal reset pulse length used here
	logic            CLK = 1'b0;
	logic            RST_N = 1'b0;
	logic            WAKE_EVENT_IN = 1'b0;
	logic            DS_VALID = 1'b0;
	logic [31:0]     DS_ADDR = 32'h00000000;
	logic [31:0]     PRDATA, FWD_ADDR, rdv, ir_cnt;
	logic            PREADY, PSLVERR, FWD_VALID, WAKE_EVENT_OUT_N, INTERNAL_RESET, IRQ, erv;
	logic [4:0]      WAKE_CAPABILITY;
	pmw_apb_req_type req;
	int              errors = 0;
	int              n_checks = 0;

	always #12.5 CLK = ~CLK;
	// Counts internal reset cycles
	always @(posedge CLK) if (INTERNAL_RESET === 1'b1) ir_cnt <= ir_cnt + 32'h1;

	pmw_csr #(.RESET_CYCLES(IRST)) pmw_csr_inst (.CLK(CLK), .RST_N(RST_N), .PSEL(req.psel),
		.PENABLE(req.penable), .PWRITE(req.pwrite), .PADDR(req.paddr), .PWDATA(req.pwdata),
		.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .WAKE_EVENT_IN(WAKE_EVENT_IN),
		.DS_VALID(DS_VALID), .DS_ADDR(DS_ADDR), .FWD_VALID(FWD_VALID), .FWD_ADDR(FWD_ADDR),
		.WAKE_EVENT_OUT_N(WAKE_EVENT_OUT_N), .INTERNAL_RESET(INTERNAL_RESET),
		.WAKE_CAPABILITY(WAKE_CAPABILITY), .IRQ(IRQ));
	pmw_host pmw_host_inst (.CLK(CLK), .PREADY(PREADY), .PSLVERR(PSLVERR), .PRDATA(PRDATA), .req(req));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		bit tmo;
		pmw_host_inst.xfer(w, a, d, rdv, erv, tmo);
		if (tmo) begin
			errors++;
			stop_test();
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		acc(1'b0, a, 32'h0);
		chk(rdv, exp);
	endtask
	// One downstream address, forwarded result sampled a cycle later
	task automatic fwd(input logic [31:0] a, input logic [31:0] exp);
		@(posedge CLK);
		DS_VALID <= 1'b1;
		DS_ADDR <= a;
		@(posedge CLK);
		DS_VALID <= 1'b0;
		DS_ADDR <= ~a;
		#1;
		chk({31'h0, FWD_VALID}, 32'h1);
		chk(FWD_ADDR, exp);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		rd(PMW_OFS_PMCSR, 32'h00000000);
		rd(PMW_OFS_XLAT, 32'h00000000);
		rd(PMW_OFS_SETUP, 32'hFFFFF000);
		chk({27'h0, WAKE_CAPABILITY}, 32'h00000019);
		rd(8'hC0, 32'h00000000);
		chk({31'h0, erv}, 32'h1);
		$display("test reset done");
	endtask
	task automatic t_power();
		acc(1'b1, PMW_OFS_PMCSR, 32'h00000003);
		rd(PMW_OFS_PMCSR, 32'h00000003);
		acc(1'b1, PMW_OFS_PMCSR, 32'h00000001);
		acc(1'b1, PMW_OFS_PMCSR, 32'h00000002);
		rd(PMW_OFS_PMCSR, 32'h00000003);
		acc(1'b1, PMW_OFS_XLAT, 32'hFFFFF000);
		ir_cnt = 32'h0;
		acc(1'b1, PMW_OFS_PMCSR, 32'h00000000);
		repeat (IRST + 4) @(posedge CLK);
		chk(ir_cnt, IRST);
		rd(PMW_OFS_PMCSR, 32'h00000000);
		rd(PMW_OFS_XLAT, 32'h00000000);
		$display("test power done");
	endtask
	task automatic t_window();
		acc(1'b1, PMW_OFS_XLAT, 32'hABCDE123);
		rd(PMW_OFS_XLAT, 32'hABCDE000);
		acc(1'b1, PMW_OFS_SETUP, 32'h00000000);
		rd(PMW_OFS_SETUP, 32'hFFFFF000);
		acc(1'b1, PMW_OFS_SETUP_LD, 32'h0FFFF00A);
		rd(PMW_OFS_SETUP, 32'h8FFFF00A);
		fwd(32'h55555123, 32'hDBCDE123);
		acc(1'b1, PMW_OFS_SETUP_LD, 32'h80000006);
		rd(PMW_OFS_SETUP, 32'h80000000);
		fwd(32'h55555123, 32'hD5555123);
		$display("test window done");
	endtask
	task automatic t_wake();
		int n;
		chk({31'h0, IRQ}, 32'h0);  // Pending events stay masked
		acc(1'b1, PMW_OFS_IRQ_EN, 32'h00000001);
		acc(1'b1, PMW_OFS_PMCSR, 32'h00000100);
		chk({31'h0, WAKE_EVENT_OUT_N}, 32'h1);
		@(posedge CLK);
		WAKE_EVENT_IN <= 1'b1;
		for (n = 0; n < 10 && WAKE_EVENT_OUT_N !== 1'b0; n++) begin
			@(posedge CLK);
			#1;
		end
		chk({31'h0, WAKE_EVENT_OUT_N}, 32'h0);
		chk({31'h0, IRQ}, 32'h1);
		@(posedge CLK);
		WAKE_EVENT_IN <= 1'b0;
		rd(PMW_OFS_PMCSR, 32'h00008100);
		acc(1'b1, PMW_OFS_PMCSR, 32'h00000000);
		repeat (2) @(posedge CLK);
		#1;
		chk({31'h0, WAKE_EVENT_OUT_N}, 32'h1);
		rd(PMW_OFS_PMCSR, 32'h00008000);
		acc(1'b1, PMW_OFS_PMCSR, 32'h00008000);
		rd(PMW_OFS_PMCSR, 32'h00000000);
		rd(PMW_OFS_IRQ_STAT, 32'h00000007);
		acc(1'b1, PMW_OFS_IRQ_CLR, 32'h00000007);
		rd(PMW_OFS_IRQ_STAT, 32'h00000000);
		chk({31'h0, IRQ}, 32'h0);
		$display("test wake done");
	endtask

	// Main sequence: reset held four cycles, then scenarios
	initial begin
		ir_cnt = 32'h0;
		repeat (4) @(posedge CLK);
		RST_N <= 1'b1;
		t_reset();
		t_power();
		t_window();
		t_wake();
		stop_test();
	end
endmodule // pmw_csr_tb_top
